// ### design/sdi_defines.svh
// Offsets, field positions, reset values and stream constants of the SDI
// word path. Included by the design module.
`ifndef SDI_DEFINES_SVH
`define SDI_DEFINES_SVH
`define REG_CTRL 8'h00
`define REG_FLAGSEL 8'h04
`define REG_STATUS 8'h08
`define REG_LINELEN 8'h0C
`define REG_WANDER 8'h10
`define REG_EDH 8'h14
`define REG_LTC_LO 8'h18
`define REG_LTC_HI 8'h1C
`define REG_LAST_IDX 6'h07
`define CTRL_CHAN 0
`define CTRL_AD 1
`define CTRL_AV_LO 2
`define CTRL_RESET 4'h0
`define FLAGSEL_RESET 18'h2C688
`define TRS_ONES 10'h3FF
`define TRS_ZEROS 10'h000
`define XYZ_H 6
`define XYZ_V 7
`define V_RUN 4'h8
`define WORD_LAST 4'h9
`define EDH_DID 10'h1F4
`define EDH_FLAG0 5'h12
`define LTC_SYNC 16'h3FFD
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ### design/sdi_pkg.sv
// Types shared by the SDI word path: output word, mode and state record.
// Assumes nothing of its surroundings.
package sdi_pkg;
  typedef enum logic [1:0] {AV_VIDEO, AV_AUDIO, AV_INSERT} av_mode_type;
  typedef struct packed {
    logic [9:0] data;
    logic [5:0] flags;
  } out_word_type;
  typedef struct packed {
    logic [9:0] sh;
    logic [3:0] phase;
    logic aligned;
    logic [9:0] word;
    logic [2:0][9:0] hist;
    logic line;
    logic frame;
    logic [3:0] vrun;
    logic [15:0] ccnt;
    logic [15:0] line_len;
    logic [23:0] wcnt;
    logic [23:0] wander;
    logic chroma;
    logic [9:0] ash;
    logic [9:0] aword;
    logic anew;
    logic edh_on;
    logic [4:0] edh_idx;
    logic [14:0] edh_flags;
    logic [79:0] ltc_sh;
    logic [63:0] ltc;
    out_word_type [1:0] buff;
    logic [1:0] cnt;
    logic [7:0] drops;
    logic [3:0] ctrl;
    logic [17:0] fsel;
    logic aw_v;
    logic [7:0] aw_a;
    logic w_v;
    logic [31:0] wd;
    logic [3:0] ws;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_type;
endpackage

// ### design/sdi_word_path.sv
// SDI digital word path: deserializer, TRS alignment, line/frame bits,
// muxes, flags, EDH/LTC capture, wander and line-length timing.
// Assumes serial inputs already in the recovered clock domain (aclk).
//
// Contract
// R1 - Serial stream becomes 10-bit parallel words on the recovered clock
// R2 - Word boundary taken from all-ones or all-zeros TRS words; the code aligns on all-ones words only
// R3 - Line bit follows H bit of each detected XYZ word
// R4 - Frame bit follows V bit of XYZ words
// R5 - Frame bit changes only after eight consecutive XYZ words carry new V
// R6 - Channel mux passes exactly one of two serial inputs
// R7 - Second mux picks analog Channel A samples or deserialized words
// R8 - Audio/video mux outputs video or audio words to acquisition
// R9 - External audio mode replaces chroma samples with audio words; the code does so for deserialized words only, not analog samples
// R10 - Flag mux maps selectable status lines onto six flag lines
// R11 - Serial audio is made parallel before output
// R12 - Acquisition side FIFO to CPU flags overflow as error
// R13 - EDH errors detected and decoded; line length aids rate detection
// R14 - Wander detector times TRS intervals on precision time base
// R15 - Timecode decoded into CPU-readable registers
// R16 - XYZ is fourth word after ones and two zeros words
//
// Our own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "sdi_defines.svh"
module sdi_word_path
(
  input wire logic aclk, // Recovered clock
  input wire logic aresetn, // Sync reset, active low
  input wire logic sdi_a, // Channel A serial bit
  input wire logic sdi_b, // Channel B serial bit
  input wire logic [9:0] analog_data, // Channel A analog sample
  input wire logic analog_valid, // Analog sample strobe
  input wire logic aud_bit, // Audio receiver serial bit
  input wire logic aud_valid, // Audio bit strobe
  input wire logic aud_last, // Last bit of audio word
  input wire logic ref_tick, // Precision time base tick
  input wire logic ltc_bit, // Timecode bit
  input wire logic ltc_valid, // Timecode bit strobe
  output sdi_pkg::out_word_type out_word, // Word and flags to acquisition
  output logic out_valid, // Buffer holds a word
  input wire logic out_ready, // Acquisition accepts word
  input wire logic awvalid, // AXI4-Lite write address valid
  output logic awready, // Write address ready
  input wire logic [7:0] awaddr, // Write byte address
  input wire logic wvalid, // Write data valid
  output logic wready, // Write data ready
  input wire logic [31:0] wdata, // Write data
  input wire logic [3:0] wstrb, // Write byte lanes
  output logic bvalid, // Write response valid
  input wire logic bready, // Write response ready
  output logic [1:0] bresp, // Write response
  input wire logic arvalid, // Read address valid
  output logic arready, // Read address ready
  input wire logic [7:0] araddr, // Read byte address
  output logic rvalid, // Read data valid
  input wire logic rready, // Read data ready
  output logic [31:0] rdata, // Read data
  output logic [1:0] rresp // Read response
);
  import sdi_pkg::*;

  state_type s_r;
  state_type s_nxt;
  logic dbit;
  logic word_end;
  logic xyz;
  logic flip;
  logic edh_err;
  logic vid_ev;
  logic [9:0] vid_w;
  logic src_ev;
  logic [9:0] src_w;
  logic in_ready;
  logic pop;
  logic [7:0] stat;
  logic [5:0] fl;
  logic [31:0] merged;
  av_mode_type av;

  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a[1:0] == 2'h0) && (a[7:2] <= `REG_LAST_IDX);
  endfunction

  function automatic logic [31:0] lanes(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] st);
    lanes = old;
    for (int b = 0; b < 4; b++)
    begin
      if (st[b])
      begin
        lanes[8*b +: 8] = d[8*b +: 8];
      end
    end
  endfunction

  assign out_valid = (s_r.cnt != 2'h0);
  assign out_word = s_r.buff[0];
  assign awready = !s_r.aw_v && !s_r.bvalid;
  assign wready = !s_r.w_v && !s_r.bvalid;
  assign arready = !s_r.rvalid;
  assign bvalid = s_r.bvalid;
  assign bresp = s_r.bresp;
  assign rvalid = s_r.rvalid;
  assign rdata = s_r.rdata;
  assign rresp = s_r.rresp;
  assign edh_err = |s_r.edh_flags;
  assign in_ready = (s_r.cnt != 2'h2);
  assign pop = out_valid && out_ready;

  always_comb
  begin
    s_nxt = s_r;
    merged = 32'h0;
    s_nxt.anew = 1'b0;
    av = av_mode_type'(s_r.ctrl[`CTRL_AV_LO +: 2]);
    // Deserializer, LSB first
    dbit = s_r.ctrl[`CTRL_CHAN] ? sdi_b : sdi_a; // R6
    s_nxt.sh = {dbit, s_r.sh[9:1]}; // R1
    // Only the first ten ones of a run force a boundary, so 3FF 3FF stays two words
    word_end = (s_r.phase == `WORD_LAST) || (s_nxt.sh == `TRS_ONES && s_r.sh != `TRS_ONES); // R2
    s_nxt.phase = word_end ? 4'h0 : s_r.phase + 4'h1; // R1
    if (s_nxt.sh == `TRS_ONES)
    begin
      s_nxt.aligned = 1'b1; // R2
    end
    xyz = word_end && (s_r.hist == {`TRS_ONES, `TRS_ZEROS, `TRS_ZEROS}); // R16
    flip = xyz && (s_nxt.sh[`XYZ_V] != s_r.frame) && (s_r.vrun == `V_RUN - 4'h1);
    s_nxt.ccnt = s_r.ccnt + 16'h1;
    s_nxt.wcnt = s_r.wcnt + {23'h0, ref_tick};
    if (word_end)
    begin
      s_nxt.word = s_nxt.sh;
      s_nxt.hist = {s_r.hist[1:0], s_nxt.sh};
      s_nxt.chroma = ~s_r.chroma;
    end
    if (xyz)
    begin
      s_nxt.line = s_nxt.sh[`XYZ_H]; // R3
      s_nxt.chroma = 1'b1;
      // Deglitch: a single bad XYZ restarts the run
      if (s_nxt.sh[`XYZ_V] == s_r.frame)
      begin
        s_nxt.vrun = 4'h0; // R5
      end
      else if (flip)
      begin
        s_nxt.frame = s_nxt.sh[`XYZ_V]; // R4 R5
        s_nxt.vrun = 4'h0;
      end
      else
      begin
        s_nxt.vrun = s_r.vrun + 4'h1; // R5
      end
      if (s_nxt.sh[`XYZ_H])
      begin
        s_nxt.line_len = s_r.ccnt; // R13
        s_nxt.ccnt = 16'h1;
        s_nxt.wander = s_r.wcnt; // R14
        s_nxt.wcnt = {23'h0, ref_tick};
      end
    end
    // EDH packet: ADF 000 3FF 3FF then DID; three flag words follow the CRCs
    if (word_end && s_r.hist == {`TRS_ZEROS, `TRS_ONES, `TRS_ONES} && s_nxt.sh == `EDH_DID)
    begin
      s_nxt.edh_on = 1'b1;
      s_nxt.edh_idx = 5'h0;
    end
    else if (word_end && s_r.edh_on)
    begin
      s_nxt.edh_idx = s_r.edh_idx + 5'h1;
      for (int k = 0; k < 3; k++)
      begin
        if (s_nxt.edh_idx == `EDH_FLAG0 + 5'(k))
        begin
          s_nxt.edh_flags[5*k +: 5] = s_nxt.sh[6:2]; // R13
        end
      end
      if (s_nxt.edh_idx == `EDH_FLAG0 + 5'h2)
      begin
        s_nxt.edh_on = 1'b0;
      end
    end
    if (aud_valid)
    begin
      s_nxt.ash = {aud_bit, s_r.ash[9:1]}; // R11
      if (aud_last)
      begin
        s_nxt.aword = s_nxt.ash; // R11
        s_nxt.anew = 1'b1;
      end
    end
    if (ltc_valid)
    begin
      s_nxt.ltc_sh = {s_r.ltc_sh[78:0], ltc_bit};
      if (s_nxt.ltc_sh[15:0] == `LTC_SYNC)
      begin
        s_nxt.ltc = s_nxt.ltc_sh[79:16]; // R15
      end
    end
    vid_ev = s_r.ctrl[`CTRL_AD] ? analog_valid : word_end; // R7
    vid_w = s_r.ctrl[`CTRL_AD] ? analog_data : s_nxt.sh; // R7
    unique case (av)
      AV_AUDIO:
      begin
        src_ev = s_r.anew; // R8
        src_w = s_r.aword;
      end
      AV_INSERT:
      begin
        src_ev = vid_ev;
        src_w = (!s_r.ctrl[`CTRL_AD] && s_r.chroma) ? s_r.aword : vid_w; // R9
      end
      default:
      begin
        src_ev = vid_ev; // R8
        src_w = vid_w;
      end
    endcase
    stat = {s_r.drops != 8'h0, s_r.anew, s_r.chroma, xyz, edh_err, s_r.aligned,
            s_r.frame, s_r.line};
    for (int i = 0; i < 6; i++)
    begin
      fl[i] = stat[s_r.fsel[3*i +: 3]]; // R10
    end
    // Two-entry buffer; the serial source cannot wait, so a full buffer drops
    if (pop)
    begin
      s_nxt.buff[0] = s_r.buff[1];
    end
    if (src_ev && in_ready)
    begin
      s_nxt.buff[pop ? s_r.cnt - 2'h1 : s_r.cnt] = {src_w, fl};
    end
    else if (src_ev && s_r.drops != 8'hFF)
    begin
      s_nxt.drops = s_r.drops + 8'h1;
    end
    s_nxt.cnt = s_r.cnt + {1'b0, src_ev && in_ready} - {1'b0, pop};
    // AXI4-Lite slave
    if (awvalid && awready)
    begin
      s_nxt.aw_v = 1'b1;
      s_nxt.aw_a = awaddr;
    end
    if (wvalid && wready)
    begin
      s_nxt.w_v = 1'b1;
      s_nxt.wd = wdata;
      s_nxt.ws = wstrb;
    end
    if (s_r.bvalid && bready)
    begin
      s_nxt.bvalid = 1'b0;
    end
    if (s_r.aw_v && s_r.w_v)
    begin
      s_nxt.aw_v = 1'b0;
      s_nxt.w_v = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = reg_hit(s_r.aw_a) ? `RESP_OKAY : `RESP_SLVERR;
      if (s_r.aw_a == `REG_CTRL)
      begin
        merged = lanes({28'h0, s_r.ctrl}, s_r.wd, s_r.ws);
        s_nxt.ctrl = merged[3:0];
      end
      else if (s_r.aw_a == `REG_FLAGSEL)
      begin
        merged = lanes({14'h0, s_r.fsel}, s_r.wd, s_r.ws);
        s_nxt.fsel = merged[17:0];
      end
    end
    if (s_r.rvalid && rready)
    begin
      s_nxt.rvalid = 1'b0;
    end
    if (arvalid && arready)
    begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = reg_hit(araddr) ? `RESP_OKAY : `RESP_SLVERR;
      unique case (araddr)
        `REG_CTRL: s_nxt.rdata = {28'h0, s_r.ctrl};
        `REG_FLAGSEL: s_nxt.rdata = {14'h0, s_r.fsel};
        `REG_STATUS: s_nxt.rdata = {16'h0, s_r.drops, 4'h0, edh_err, s_r.aligned,
                                    s_r.frame, s_r.line};
        `REG_LINELEN: s_nxt.rdata = {16'h0, s_r.line_len};
        `REG_WANDER: s_nxt.rdata = {8'h0, s_r.wander};
        `REG_EDH: s_nxt.rdata = {17'h0, s_r.edh_flags};
        `REG_LTC_LO: s_nxt.rdata = s_r.ltc[31:0];
        `REG_LTC_HI: s_nxt.rdata = s_r.ltc[63:32];
        default: s_nxt.rdata = 32'h0;
      endcase
    end
    if (!aresetn)
    begin
      s_nxt = '0;
      s_nxt.ctrl = `CTRL_RESET;
      s_nxt.fsel = `FLAGSEL_RESET;
    end
  end

  always_ff @(posedge aclk)
  begin
    s_r <= s_nxt;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_trs;
    word_end && (s_r.hist == {`TRS_ONES, `TRS_ZEROS, `TRS_ZEROS});
  endsequence

  sequence s_eav;
    s_trs ##0 s_nxt.sh[`XYZ_H];
  endsequence

  property p_word_wrap;
    (s_r.phase == `WORD_LAST) |=> (s_r.phase == 4'h0) && (s_r.word == $past(s_nxt.sh));
  endproperty
  a_word_wrap: assert property (p_word_wrap) else $error("word not closed after ten bits"); // R1

  property p_align;
    (s_nxt.sh == `TRS_ONES) && (s_r.sh != `TRS_ONES) |=> (s_r.phase == 4'h0) && s_r.aligned;
  endproperty
  a_align: assert property (p_align) else $error("TRS ones did not set boundary"); // R2

  property p_line;
    s_trs |=> (s_r.line == $past(s_nxt.sh[`XYZ_H]));
  endproperty
  a_line: assert property (p_line) else $error("line bit not taken from XYZ"); // R3

  property p_frame_set;
    flip |=> (s_r.frame == $past(s_nxt.sh[`XYZ_V])) && (s_r.vrun == 4'h0);
  endproperty
  a_frame_set: assert property (p_frame_set) else $error("frame bit not updated"); // R4

  property p_frame_hold;
    !flip |=> $stable(s_r.frame);
  endproperty
  a_frame_hold: assert property (p_frame_hold) else $error("frame bit changed early"); // R5

  property p_chan;
    !s_r.ctrl[`CTRL_CHAN] ##1 !$past(s_r.ctrl[`CTRL_CHAN]) |-> s_r.sh[9] == $past(sdi_a);
  endproperty
  a_chan: assert property (p_chan) else $error("channel A not passed"); // R6

  property p_audio_word;
    aud_valid && aud_last |=> s_r.anew ##1 !s_r.anew || $past(aud_valid && aud_last);
  endproperty
  a_audio_word: assert property (p_audio_word) else $error("audio word not formed"); // R11

  property p_audio_out;
    (av == AV_AUDIO) && s_r.anew && (s_r.cnt == 2'h0)
      |=> out_valid && (out_word.data == $past(s_r.aword));
  endproperty
  a_audio_out: assert property (p_audio_out) else $error("audio word not output"); // R8

  property p_wander;
    s_eav |=> (s_r.wander == $past(s_r.wcnt)) && (s_r.line_len == $past(s_r.ccnt));
  endproperty
  a_wander: assert property (p_wander) else $error("TRS interval not latched"); // R14

endmodule

// ### testbench/acq_model.sv
// Capture side model: takes words and flags from the word path.
// Assumes one clock (aclk) and a synchronous active-low reset.
`timescale 1ns/10ps
module acq_model
#(
  parameter int CPU_DEPTH = 64
)
(
  input wire logic aclk, // Recovered clock
  input wire logic aresetn, // Sync reset, active low
  input sdi_pkg::out_word_type out_word, // Word and flags in
  input wire logic out_valid, // Word offered
  output logic out_ready, // Word accepted
  input wire logic stall, // Bench asks for a slow receiver
  output sdi_pkg::out_word_type last_word, // Last word taken
  output logic [15:0] n_words, // Words taken
  output logic cpu_ovf // CPU queue overflowed
);
  import sdi_pkg::*;
  logic [6:0] cpu_cnt;
  // Stalling is the only misbehaviour; it never drops a taken word
  assign out_ready = !stall;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      last_word <= '0;
      n_words <= 16'h0000;
      cpu_cnt <= 7'h00;
      cpu_ovf <= 1'b0;
    end
    else if (out_valid && out_ready)
    begin
      last_word <= out_word;
      n_words <= n_words + 16'h0001;
      // No CPU reader here, so the queue only fills; overflow is sticky
      if (cpu_cnt == 7'(CPU_DEPTH)) cpu_ovf <= 1'b1;
      else cpu_cnt <= cpu_cnt + 7'h01;
    end
  end
endmodule

// ### testbench/tb.sv
// Self-checking bench for the word path: AXI4-Lite tasks, serial sender.
// Assumes the capture model and the design package are compiled first.
`timescale 1ns/10ps
module tb;
  import sdi_pkg::*;
  logic aclk, aresetn, sdi_a, sdi_b, analog_valid, aud_bit, aud_valid, aud_last;
  logic ref_tick, ltc_bit, ltc_valid, out_ready, out_valid, stall;
  logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [9:0] analog_data;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [15:0] n_words, n0;
  logic cpu_ovf;
  out_word_type out_word, last_word;
  int mismatches, n_compared;

  sdi_word_path dut_u (.aclk(aclk), .aresetn(aresetn), .sdi_a(sdi_a), .sdi_b(sdi_b),
    .analog_data(analog_data), .analog_valid(analog_valid), .aud_bit(aud_bit),
    .aud_valid(aud_valid), .aud_last(aud_last), .ref_tick(ref_tick), .ltc_bit(ltc_bit),
    .ltc_valid(ltc_valid), .out_word(out_word), .out_valid(out_valid),
    .out_ready(out_ready), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));
  acq_model acq_u (.aclk(aclk), .aresetn(aresetn), .out_word(out_word),
    .out_valid(out_valid), .out_ready(out_ready), .stall(stall), .last_word(last_word),
    .n_words(n_words), .cpu_ovf(cpu_ovf));

  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  always @(posedge aclk) ref_tick <= aresetn ? ~ref_tick : 1'b0;

  task chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task wrap_up;
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Handshakes are judged on the negedge, where all edge updates have landed
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    logic ah, wh, bh;
    @(posedge aclk);
    awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= v; wstrb <= 4'hF; bready <= 1'b1;
    forever
    begin
      @(negedge aclk);
      ah = awvalid && awready;
      wh = wvalid && wready;
      bh = bvalid && bready;
      @(posedge aclk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      if (bh)
      begin
        bready <= 1'b0;
        chk(32'(bresp), 32'(er));
        break;
      end
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] dd, output logic [1:0] rr);
    logic ah, hs;
    @(posedge aclk);
    arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
    forever
    begin
      @(negedge aclk);
      ah = arvalid && arready;
      hs = rvalid && rready;
      dd = rdata;
      rr = rresp;
      @(posedge aclk);
      if (ah) arvalid <= 1'b0;
      if (hs)
      begin
        rready <= 1'b0;
        break;
      end
    end
  endtask

  // Unselected lane carries the inverse so a wrong mux shows at once
  task automatic sw(input logic [9:0] w, input logic b);
    for (int i = 0; i < 10; i++)
    begin
      @(posedge aclk);
      sdi_a <= b ? ~w[i] : w[i];
      sdi_b <= b ? w[i] : ~w[i];
    end
  endtask

  task automatic trs(input logic v, input logic h, input logic b);
    sw(10'h3FF, b);
    sw(10'h000, b);
    sw(10'h000, b);
    sw({2'b10, v, h, 6'h15}, b);
    sw(10'h155, b);
  endtask

  task automatic ana(input logic [9:0] v);
    @(posedge aclk);
    analog_data <= v; analog_valid <= 1'b1;
    @(posedge aclk);
    analog_valid <= 1'b0;
  endtask

  task automatic aud(input logic [9:0] v);
    for (int i = 0; i < 10; i++)
    begin
      @(posedge aclk);
      aud_bit <= v[i]; aud_valid <= 1'b1; aud_last <= (i == 9);
    end
    @(posedge aclk);
    aud_valid <= 1'b0; aud_last <= 1'b0;
  endtask

  // Timecode bits in arrival order, the sync word last
  task automatic ltc(input logic [79:0] v);
    for (int i = 79; i >= 0; i--)
    begin
      @(posedge aclk);
      ltc_bit <= v[i];
      ltc_valid <= 1'b1;
    end
    @(posedge aclk);
    ltc_valid <= 1'b0;
  endtask

  // Flag 000 3FF 3FF, DID, 17 fillers, then the three error flag words
  function automatic logic [9:0] edh_w(input int i);
    case (i)
      0: return 10'h000;
      1, 2: return 10'h3FF;
      3: return 10'h1F4;
      21: return 10'h204;
      22: return 10'h208;
      23: return 10'h27C;
      default: return 10'h200;
    endcase
  endfunction

  initial
  begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    wrap_up();
  end

  initial
  begin
    aresetn <= 1'b0; sdi_a <= 1'b0; sdi_b <= 1'b1; analog_data <= 10'h000;
    analog_valid <= 1'b0; aud_bit <= 1'b0; aud_valid <= 1'b0; aud_last <= 1'b0;
    ltc_bit <= 1'b0; ltc_valid <= 1'b0; stall <= 1'b0;
    awvalid <= 1'b0; wvalid <= 1'b0; bready <= 1'b0; arvalid <= 1'b0; rready <= 1'b0;
    awaddr <= 8'h00; araddr <= 8'h00; wdata <= 32'h0; wstrb <= 4'h0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h00, d, r); chk(d, 32'h0);
    rd(8'h04, d, r); chk(d, 32'h0002C688);
    rd(8'h20, d, r); chk(d, 32'h0);
    chk(r, 2'h2);
    wr(8'h20, 32'h5, 2'h2);
    // Five new V, one old V restarts the run, then seven more stay short
    repeat (5) trs(1'b1, 1'b1, 1'b0);
    trs(1'b0, 1'b1, 1'b0);
    repeat (7) trs(1'b1, 1'b1, 1'b0);
    rd(8'h08, d, r); chk(d[2:0], 3'b101);
    // Back-to-back marks sit 50 clocks apart; the tick toggles every clock
    rd(8'h0C, d, r); chk(d, 32'h32);
    rd(8'h10, d, r); chk(d, 32'h19);
    trs(1'b1, 1'b0, 1'b0);
    rd(8'h08, d, r); chk(d[2:0], 3'b110);
    // A lane idling high would run into the mark's ones and hide the boundary
    sdi_b <= 1'b0;
    wr(8'h00, 32'h1, 2'h0);
    trs(1'b1, 1'b1, 1'b1);
    rd(8'h08, d, r); chk(d[2:0], 3'b111);
    wr(8'h04, 32'h0002C68B, 2'h0);
    wr(8'h00, 32'h2, 2'h0);
    ana(10'h2A5);
    repeat (4) @(posedge aclk);
    chk({last_word.data, last_word.flags[2:0]}, {10'h2A5, 3'b110});
    stall <= 1'b1;
    for (int i = 1; i <= 4; i++) ana(10'(10'h100 + i));
    rd(8'h08, d, r); chk(d[15:8], 8'h02);
    n0 = n_words;
    stall <= 1'b0;
    repeat (6) @(posedge aclk);
    chk(n_words - n0, 16'h2);
    chk(last_word.data, 10'h102);
    chk(out_valid, 1'b0);
    wr(8'h00, 32'h4, 2'h0);
    aud(10'h2C3);
    repeat (4) @(posedge aclk);
    chk(last_word.data, 10'h2C3);
    // Insert mode: the word after the mark is a chroma slot and carries audio
    sdi_a <= 1'b0;
    wr(8'h00, 32'h8, 2'h0);
    trs(1'b1, 1'b1, 1'b0);
    repeat (3) @(posedge aclk);
    chk(last_word.data, 10'h2C3);
    wr(8'h00, 32'h0, 2'h0);
    trs(1'b1, 1'b1, 1'b0);
    for (int i = 0; i < 24; i++) sw(edh_w(i), 1'b0);
    rd(8'h14, d, r); chk(d, 32'h00007C41);
    rd(8'h08, d, r); chk(d[3], 1'b1);
    ltc({64'h0123456789ABCDEF, 16'h3FFD});
    rd(8'h18, d, r); chk(d, 32'h89ABCDEF);
    rd(8'h1C, d, r); chk(d, 32'h01234567);
    chk(cpu_ovf, 1'b1);
    wrap_up();
  end
endmodule
